// file: rtl/mbb_bus_if.sv
// multiplexed burst bus interface unit, device end
`timescale 1ns/1ps

module mbb_bus_if
  import mbb_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  // user request port
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_write_in,
  input  wire logic [1:0]  req_kind_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [2:0]  req_beats_in,
  input  wire logic [1:0]  req_be_in,
  input  wire logic [15:0] wr_data_in,
  output logic             wr_take_out,
  output logic [15:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             done_out,
  // bus pins
  output logic [15:0]      upper_address_lines_out,
  input  wire logic [15:0] muxed_addr_data_lines_in,
  output logic [15:0]      muxed_addr_data_lines_out,
  output logic             muxed_addr_data_oe_out,
  output logic [2:0]       burst_word_address_out,
  output logic             ale_out,
  output logic             address_state_strobe_n_out,
  output logic             write_read_out,
  output logic             data_phase_enable_n_out,
  output logic             transfer_direction_out,
  output logic             final_beat_strobe_n_out,
  output logic [1:0]       byte_lane_enables_n_out,
  output logic             bus_oe_out,
  input  wire logic        ready_n_in,
  input  wire logic        hold_in,
  output logic             bus_grant_out,
  input  wire logic        lock_n_in,
  output logic             lock_n_out,
  output logic             lock_oe_out
);

  // ==========================================================================
  // state
  mbb_regs_s r_reg;
  mbb_regs_s r_next;
  logic      tick;
  logic      accept;
  logic      lock_busy;
  logic      wtake;

  assign tick      = r_reg.phase;
  assign lock_busy = ~r_reg.lock_s2;

  // ==========================================================================
  // next state
  always_comb begin
    r_next        = r_reg;
    wtake         = 1'b0;
    accept        = 1'b0;
    r_next.phase  = ~r_reg.phase;
    r_next.ready_s1 = ready_n_in;
    r_next.ready_s2 = r_reg.ready_s1;
    r_next.hold_s1  = hold_in;
    r_next.hold_s2  = r_reg.hold_s1;
    r_next.lock_s1  = lock_n_in;
    r_next.lock_s2  = r_reg.lock_s1;
    r_next.ad_s1    = muxed_addr_data_lines_in;
    r_next.ad_s2    = r_reg.ad_s1;
    r_next.rd_valid = 1'b0;
    r_next.done     = 1'b0;
    if (r_reg.st == ST_ADDR && !tick) begin
      r_next.ale = 1'b0;
    end
    if (tick) begin
      case (r_reg.st)
        ST_IDLE: begin
          if (r_reg.hold_s2 && !r_reg.lock_hold) begin
            r_next.st     = ST_HOLD;
            r_next.grant  = 1'b1;
            r_next.bus_oe = 1'b0;
            r_next.ad_oe  = 1'b0;
            r_next.ale    = 1'b0;
          end else if (req_valid_in && !(req_kind_in == KIND_RMW_RD && lock_busy)) begin
            accept           = 1'b1;
            r_next.st        = ST_ADDR;
            r_next.addr      = req_addr_in;
            r_next.write     = req_write_in;
            r_next.kind      = req_kind_in;
            r_next.be        = req_be_in;
            r_next.left      = req_beats_in;
            r_next.ale       = 1'b1;
            r_next.as_n      = 1'b0;
            r_next.dtr       = req_write_in;
            r_next.ad_out    = req_addr_in[15:0];
            r_next.ad_oe     = 1'b1;
            r_next.word_addr = req_addr_in[3:1];
            if (req_kind_in == KIND_RMW_RD || req_kind_in == KIND_INTACK) begin
              r_next.lock_hold = 1'b1;
            end else if (req_kind_in == KIND_RMW_WR) begin
              r_next.lock_hold = 1'b0;
            end
          end
        end
        ST_ADDR: begin
          r_next.st      = ST_DATA;
          r_next.as_n    = 1'b1;
          r_next.den_n   = 1'b0;
          r_next.be_n    = ~r_reg.be;
          r_next.final_beat_strobe_n = (r_reg.left != LAST_BEAT);
          r_next.ad_oe   = r_reg.write;
          if (r_reg.write) begin
            r_next.ad_out = wr_data_in;
            wtake         = 1'b1;
          end
        end
        ST_DATA: begin
          // synced ready and data still show the previous beat here
          r_next.st = ST_WAIT;
        end
        ST_WAIT: begin
          if (r_reg.ready_s2) begin
            r_next.st = ST_WAIT;
          end else begin
            if (!r_reg.write) begin
              r_next.rd_data  = r_reg.ad_s2;
              r_next.rd_valid = 1'b1;
            end
            if (r_reg.left == LAST_BEAT) begin
              r_next.st      = ST_IDLE;
              r_next.den_n   = 1'b1;
              r_next.final_beat_strobe_n = 1'b1;
              r_next.be_n    = 2'h3;
              r_next.ad_oe   = 1'b0;
              r_next.done    = 1'b1;
              if (r_reg.kind == KIND_INTACK) begin
                r_next.lock_hold = 1'b0;
              end
            end else begin
              r_next.st        = ST_DATA;
              r_next.left      = r_reg.left - BEAT_ONE;
              r_next.word_addr = r_reg.word_addr + 3'h1;
              r_next.final_beat_strobe_n   = (r_reg.left != BEAT_ONE);
              if (r_reg.write) begin
                r_next.ad_out = wr_data_in;
                wtake         = 1'b1;
              end
            end
          end
        end
        ST_HOLD: begin
          if (!r_reg.hold_s2) begin
            r_next.st     = ST_IDLE;
            r_next.grant  = 1'b0;
            r_next.bus_oe = 1'b1;
          end
        end
        default: begin
          r_next.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      r_reg <= REGS_RESET;
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign req_ready_out              = accept & ce_in;
  assign wr_take_out                = wtake & ce_in;
  assign rd_data_out                = r_reg.rd_data;
  assign rd_valid_out               = r_reg.rd_valid;
  assign done_out                   = r_reg.done;
  assign upper_address_lines_out    = r_reg.addr[31:16];
  assign muxed_addr_data_lines_out  = r_reg.ad_out;
  assign muxed_addr_data_oe_out     = r_reg.ad_oe;
  assign burst_word_address_out     = r_reg.word_addr;
  assign ale_out                    = r_reg.ale;
  assign address_state_strobe_n_out = r_reg.as_n;
  assign write_read_out             = r_reg.dtr;
  assign data_phase_enable_n_out    = r_reg.den_n;
  assign transfer_direction_out     = r_reg.dtr;
  assign final_beat_strobe_n_out    = r_reg.final_beat_strobe_n;
  assign byte_lane_enables_n_out    = r_reg.be_n;
  assign bus_oe_out                 = r_reg.bus_oe;
  assign bus_grant_out              = r_reg.grant;
  assign lock_n_out                 = 1'b0;
  assign lock_oe_out                = r_reg.lock_hold;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_state_on_tick;
    (r_reg.st != $past(r_reg.st)) |-> $past(r_reg.phase);
  endproperty
  a_state_on_tick: assert property (p_state_on_tick)
    else $error("bus state moved off the divided clock");

  property p_upper_stable;
    (!r_reg.den_n && $past(!r_reg.den_n)) |-> $stable(upper_address_lines_out);
  endproperty
  a_upper_stable: assert property (p_upper_stable)
    else $error("upper address changed inside burst");

  property p_word_step;
    (ce_in && tick && r_reg.st == ST_WAIT && !r_reg.ready_s2 && r_reg.left != LAST_BEAT)
      |=> burst_word_address_out == $past(r_reg.word_addr) + 3'h1;
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("word address did not step");

  property p_word_match;
    (r_reg.st == ST_ADDR) |-> burst_word_address_out == muxed_addr_data_lines_out[3:1];
  endproperty
  a_word_match: assert property (p_word_match)
    else $error("word address differs from muxed bits");

  property p_ale_window;
    (r_reg.st == ST_DATA || r_reg.st == ST_HOLD) |-> !ale_out;
  endproperty
  a_ale_window: assert property (p_ale_window)
    else $error("latch strobe high outside address state");

  property p_as_addr;
    !address_state_strobe_n_out == (r_reg.st == ST_ADDR);
  endproperty
  a_as_addr: assert property (p_as_addr)
    else $error("address state strobe mismatch");

  property p_dir_stable;
    (!data_phase_enable_n_out && $past(!data_phase_enable_n_out))
      |-> $stable(transfer_direction_out) && $stable(write_read_out);
  endproperty
  a_dir_stable: assert property (p_dir_stable)
    else $error("direction changed while data enabled");

  property p_read_float;
    (!data_phase_enable_n_out && !r_reg.write) |-> !muxed_addr_data_oe_out;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("muxed lines driven during read data");

  property p_wait;
    (ce_in && tick && (r_reg.st == ST_DATA || r_reg.st == ST_WAIT) && r_reg.ready_s2)
      |=> r_reg.st == ST_WAIT;
  endproperty
  a_wait: assert property (p_wait)
    else $error("no wait state without ready");

  property p_lock_wait;
    (req_kind_in == KIND_RMW_RD && lock_busy) |-> !req_ready_out;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("locked read started while lock busy");

  property p_final_beat_strobe;
    ((r_reg.st == ST_DATA || r_reg.st == ST_WAIT) && r_reg.left == LAST_BEAT)
      |-> !final_beat_strobe_n_out;
  endproperty
  a_final_beat_strobe: assert property (p_final_beat_strobe)
    else $error("final beat strobe missing");

  property p_hold;
    (r_reg.st == ST_HOLD) |-> bus_grant_out && !bus_oe_out && !muxed_addr_data_oe_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold state without grant and float");

  property p_idle_quiet;
    (r_reg.st == ST_IDLE) |-> address_state_strobe_n_out && data_phase_enable_n_out
      && final_beat_strobe_n_out && !ale_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("strobe active while idle");

  property p_dir_read;
    (r_reg.st == ST_ADDR || !data_phase_enable_n_out) |-> transfer_direction_out == r_reg.write;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction disagrees with access kind");

  property p_lanes;
    byte_lane_enables_n_out == (data_phase_enable_n_out ? 2'h3 : ~r_reg.be);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte lane enables wrong");

  property p_lock_take;
    (r_reg.st == ST_ADDR && r_reg.kind == KIND_RMW_RD) |-> lock_oe_out;
  endproperty
  a_lock_take: assert property (p_lock_take)
    else $error("locked read without lock");

  property p_lock_free;
    (r_reg.st == ST_ADDR && r_reg.kind == KIND_RMW_WR) |-> !lock_oe_out;
  endproperty
  a_lock_free: assert property (p_lock_free)
    else $error("lock kept in closing write");

  property p_lock_intack;
    (!data_phase_enable_n_out && r_reg.kind == KIND_INTACK) |-> lock_oe_out;
  endproperty
  a_lock_intack: assert property (p_lock_intack)
    else $error("lock missing in interrupt acknowledge");

  property p_den_capture;
    ($rose(data_phase_enable_n_out) && !r_reg.write) |-> rd_valid_out;
  endproperty
  a_den_capture: assert property (p_den_capture)
    else $error("data enable rose before read capture");

  c_burst_write: cover property (r_reg.st == ST_ADDR && r_reg.write && r_reg.left == 3'h7);
  c_wait_seen: cover property (r_reg.st == ST_WAIT);
  c_hold_seen: cover property (r_reg.st == ST_HOLD ##1 r_reg.st == ST_HOLD);
  c_locked_rd: cover property (req_ready_out && req_kind_in == KIND_RMW_RD);

endmodule : mbb_bus_if

// file: rtl/mbb_pkg.sv
// constants, state encoding and state record for the burst bus interface
package mbb_pkg;

  // ==========================================================================
  // clocking
  localparam int unsigned CORE_CLK_MHZ = 25;
  localparam int unsigned CLK_DIVIDE   = 2;
  localparam int unsigned BUS_CLK_MHZ  = CORE_CLK_MHZ / CLK_DIVIDE;

  // ==========================================================================
  // widths and burst limits
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned UPPER_LSB  = 16;
  localparam int unsigned WORD_LSB   = 1;
  localparam int unsigned BEAT_W     = 3;
  localparam int unsigned MAX_BEATS  = 8;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE  = 3'h1;

  // ==========================================================================
  // transfer kinds
  localparam logic [1:0] KIND_PLAIN  = 2'h0;
  localparam logic [1:0] KIND_RMW_RD = 2'h1;
  localparam logic [1:0] KIND_RMW_WR = 2'h2;
  localparam logic [1:0] KIND_INTACK = 2'h3;

  // ==========================================================================
  // bus states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_WAIT = 5'h08,
    ST_HOLD = 5'h10
  } mbb_state_e;

  // ==========================================================================
  // whole state of the interface
  typedef struct packed {
    mbb_state_e  st;
    logic        phase;
    logic        ready_s1;
    logic        ready_s2;
    logic        hold_s1;
    logic        hold_s2;
    logic        lock_s1;
    logic        lock_s2;
    logic [15:0] ad_s1;
    logic [15:0] ad_s2;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  kind;
    logic [1:0]  be;
    logic [2:0]  left;
    logic        lock_hold;
    logic        ale;
    logic        as_n;
    logic        den_n;
    logic        dtr;
    logic        final_beat_strobe_n;
    logic [1:0]  be_n;
    logic        grant;
    logic        bus_oe;
    logic        ad_oe;
    logic [15:0] ad_out;
    logic [2:0]  word_addr;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        done;
  } mbb_regs_s;

  localparam mbb_regs_s REGS_RESET = '{
    st: ST_IDLE, phase: 1'b0, ready_s1: 1'b1, ready_s2: 1'b1,
    hold_s1: 1'b0, hold_s2: 1'b0, lock_s1: 1'b1, lock_s2: 1'b1,
    ad_s1: 16'h0000, ad_s2: 16'h0000, addr: 32'h0000_0000, write: 1'b0,
    kind: KIND_PLAIN, be: 2'h0, left: 3'h0, lock_hold: 1'b0, ale: 1'b0,
    as_n: 1'b1, den_n: 1'b1, dtr: 1'b1, final_beat_strobe_n: 1'b1, be_n: 2'h3,
    grant: 1'b0, bus_oe: 1'b1, ad_oe: 1'b0, ad_out: 16'h0000,
    word_addr: 3'h0, rd_data: 16'h0000, rd_valid: 1'b0, done: 1'b0
  };

endpackage : mbb_pkg

// file: verif/mbb_mem_model.sv
// far-side memory model answering the burst bus
`timescale 1ns/1ps
module mbb_mem_model (
  // clock and pacing
  input  wire logic        core_clk_in,
  input  wire logic [1:0]  waits_in,
  // bus pins from the device
  input  wire logic        as_n_in,
  input  wire logic        den_n_in,
  input  wire logic        dir_in,
  input  wire logic [15:0] ad_in,
  input  wire logic        ad_oe_in,
  input  wire logic [2:0]  word_in,
  input  wire logic [1:0]  be_n_in,
  // answers to the device
  output logic [15:0]      ad_out,
  output logic             ready_n_out
);
  logic [15:0] mem_reg [0:255];
  logic [4:0]  lat_reg;
  logic [2:0]  word_reg;
  logic [3:0]  cnt_reg;
  logic [15:0] last_reg = 16'h0000;
  logic [7:0]  idx;

  assign idx         = {lat_reg, word_in};
  assign ready_n_out = den_n_in | (cnt_reg < {1'b0, waits_in, 1'b0});
  // released lines show the inverse of the last value
  assign ad_out      = (!den_n_in && !dir_in) ? mem_reg[idx] : ~last_reg;

  always @(posedge core_clk_in) begin
    last_reg <= ad_out;
    word_reg <= word_in;
    if (!as_n_in && ad_oe_in)
      lat_reg <= ad_in[8:4];
    if (den_n_in || word_in != word_reg)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + {3'h0, cnt_reg != 4'hF};
    if (!den_n_in && !ready_n_out && dir_in && ad_oe_in) begin
      if (!be_n_in[1])
        mem_reg[idx][15:8] <= ad_in[15:8];
      if (!be_n_in[0])
        mem_reg[idx][7:0] <= ad_in[7:0];
    end
  end
endmodule : mbb_mem_model

// file: verif/testbench.sv
// self-checking bench for the burst bus interface
`timescale 1ns/1ps
module testbench
  import mbb_pkg::*;
;
  // ==========================================================================
  // stimulus and wires
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic        req_valid_in = 1'b0;
  logic        req_write_in = 1'b0;
  logic [1:0]  req_kind_in = 2'h0;
  logic [31:0] req_addr_in = 32'h0000_0000;
  logic [2:0]  req_beats_in = 3'h0;
  logic [1:0]  req_be_in = 2'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic        hold_in = 1'b0;
  logic        other_lock = 1'b0;
  logic        req_ready_out, wr_take_out, rd_valid_out, done_out, ale_out;
  logic        address_state_strobe_n_out, write_read_out, data_phase_enable_n_out;
  logic        transfer_direction_out, final_beat_strobe_n_out, bus_oe_out;
  logic        muxed_addr_data_oe_out, ready_n_in, bus_grant_out;
  logic        lock_n_in, lock_n_out, lock_oe_out;
  logic [15:0] rd_data_out, upper_address_lines_out;
  logic [15:0] muxed_addr_data_lines_in, muxed_addr_data_lines_out;
  logic [2:0]  burst_word_address_out;
  logic [1:0]  byte_lane_enables_n_out;
  int          fails = 0;
  int          checks = 0;
  int          seed = 32'h6be9;
  int          nb;
  logic [31:0] addr;
  logic [15:0] rq[$];
  logic [15:0] wq[$];
  logic [15:0] dat[8];
  logic        cur_wr = 1'b0;
  logic [1:0]  cur_kind = 2'h0;
  int          cur_nb = 1;
  logic [1:0]  cur_be = 2'h3;
  logic [1:0]  waits = 2'h0;
  logic [15:0] exp_up = 16'h0000;

  always #20 core_clk_in = ~core_clk_in;
  // open-drain lock with pull-up, shared with another agent
  assign lock_n_in = (lock_oe_out ? lock_n_out : 1'b1) & !other_lock;

  mbb_bus_if dut (
    .core_clk_in, .srst_in, .ce_in, .req_valid_in, .req_ready_out, .req_write_in,
    .req_kind_in, .req_addr_in, .req_beats_in, .req_be_in, .wr_data_in, .wr_take_out,
    .rd_data_out, .rd_valid_out, .done_out, .upper_address_lines_out,
    .muxed_addr_data_lines_in, .muxed_addr_data_lines_out, .muxed_addr_data_oe_out,
    .burst_word_address_out, .ale_out, .address_state_strobe_n_out, .write_read_out,
    .data_phase_enable_n_out, .transfer_direction_out, .final_beat_strobe_n_out,
    .byte_lane_enables_n_out, .bus_oe_out, .ready_n_in, .hold_in, .bus_grant_out,
    .lock_n_in, .lock_n_out, .lock_oe_out
  );

  mbb_mem_model mem (
    .core_clk_in(core_clk_in), .waits_in(waits), .as_n_in(address_state_strobe_n_out),
    .den_n_in(data_phase_enable_n_out), .dir_in(transfer_direction_out),
    .ad_in(muxed_addr_data_lines_out), .ad_oe_in(muxed_addr_data_oe_out),
    .word_in(burst_word_address_out), .be_n_in(byte_lane_enables_n_out),
    .ad_out(muxed_addr_data_lines_in), .ready_n_out(ready_n_in)
  );

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic wait_for(input int sel, input logic val);
    for (int n = 0; n < 300; n++) begin
      @(negedge core_clk_in);
      if ((sel == 0 ? done_out : bus_grant_out) === val)
        return;
    end
    check(32'h0, 32'h1);
    give_verdict();
  endtask : wait_for

  task automatic xfer(input logic wr, input logic [1:0] kind, input logic [31:0] a,
                      input int beats, input logic [1:0] be);
    int n;
    @(negedge core_clk_in);
    cur_wr = wr;
    cur_kind = kind;
    cur_nb = beats;
    cur_be = be;
    exp_up = a[31:16];
    req_write_in = wr;
    req_kind_in = kind;
    req_addr_in = a;
    req_beats_in = 3'(beats - 1);
    req_be_in = be;
    req_valid_in = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 300);
    if (req_ready_out !== 1'b1) begin
      check(32'h0, 32'h1);
      give_verdict();
    end else begin
      @(negedge core_clk_in);
      req_valid_in = 1'b0;
      wait_for(0, 1'b1);
      // let the watcher take the last read beat first
      @(negedge core_clk_in);
      check(32'(rq.size()), 32'h0);
    end
  endtask : xfer

  // ==========================================================================
  // write data feed and output watcher
  always @(posedge core_clk_in)
    if (wr_take_out === 1'b1 && wq.size() > 0)
      void'(wq.pop_front());
  always @(negedge core_clk_in)
    wr_data_in <= (wq.size() > 0) ? wq[0] : 16'h0000;

  always @(negedge core_clk_in) begin
    if (rd_valid_out === 1'b1) begin
      if (rq.size() == 0)
        check(32'h1, 32'h0);
      else
        check(rd_data_out, rq.pop_front());
    end
    if (data_phase_enable_n_out === 1'b0) begin
      check(upper_address_lines_out, exp_up);
      check(transfer_direction_out, cur_wr);
      check(write_read_out, cur_wr);
      check(muxed_addr_data_oe_out, cur_wr);
      check(ale_out, 1'b0);
      check(byte_lane_enables_n_out, 2'(~cur_be));
      check(final_beat_strobe_n_out, burst_word_address_out != 3'(cur_nb - 1));
      check(32'(int'(burst_word_address_out) < cur_nb), 32'h1);
      if (cur_kind == KIND_INTACK)
        check(lock_oe_out, 1'b1);
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(negedge core_clk_in);
    check(address_state_strobe_n_out, 1'b1);
    check(data_phase_enable_n_out, 1'b1);
    check(transfer_direction_out, 1'b1);
    check(bus_grant_out, 1'b0);
    srst_in = 1'b0;
    for (int k = 0; k < 5; k++) begin
      addr = {16'($random(seed)), 7'h00, 5'($random(seed)), 4'h0};
      nb = (k == 0) ? 8 : 1 + int'($unsigned($random(seed)) % 8);
      waits = 2'h0;
      for (int i = 0; i < nb; i++) begin
        dat[i] = 16'($random(seed));
        wq.push_back(dat[i]);
      end
      xfer(1'b1, KIND_PLAIN, addr, nb, 2'h3);
      waits = 2'($random(seed));
      for (int i = 0; i < nb; i++)
        rq.push_back(dat[i]);
      xfer(1'b0, KIND_PLAIN, addr, nb, 2'h3);
    end
    // lower lane only
    wq.push_back(16'h5AC3);
    xfer(1'b1, KIND_PLAIN, addr, 1, 2'h1);
    rq.push_back({dat[0][15:8], 8'hC3});
    xfer(1'b0, KIND_PLAIN, addr, 1, 2'h3);
    // locked read waits while another agent holds the lock
    other_lock = 1'b1;
    // let the busy lock pass the synchroniser first
    repeat (2) @(negedge core_clk_in);
    rq.push_back({dat[0][15:8], 8'hC3});
    fork
      xfer(1'b0, KIND_RMW_RD, addr, 1, 2'h3);
      begin
        repeat (40) begin
          @(posedge core_clk_in);
          check(req_ready_out, 1'b0);
        end
        @(negedge core_clk_in);
        other_lock = 1'b0;
      end
    join
    check(lock_oe_out, 1'b1);
    wq.push_back(16'hE17B);
    xfer(1'b1, KIND_RMW_WR, addr, 1, 2'h3);
    check(lock_oe_out, 1'b0);
    rq.push_back(16'hE17B);
    xfer(1'b0, KIND_INTACK, addr, 1, 2'h3);
    check(lock_oe_out, 1'b0);
    // bus handed to another master and back
    hold_in = 1'b1;
    wait_for(1, 1'b1);
    check(bus_oe_out, 1'b0);
    hold_in = 1'b0;
    wait_for(1, 1'b0);
    check(bus_oe_out, 1'b1);
    check(address_state_strobe_n_out, 1'b1);
    check(data_phase_enable_n_out, 1'b1);
    give_verdict();
  end
endmodule : testbench
